// File: verilog/umsc_top.sv
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// [RULE_01] while muted no receive status flag is set and no receive event raised
// [RULE_02] wake bit chooses idle-line (0) or address-mark (1) mute handling
// [RULE_03] with idle-line wake, software writing mute one enters mute
// [RULE_04] idle frame ends mute, clears mute bit, idle flag stays clear
// [RULE_05] software writing mute zero leaves mute
// [RULE_06] address-mark: msb one means address, low four bits compared to node
// [RULE_07] unmatched address enters mute, sets no receive-not-empty flag
// [RULE_08] matched address clears mute and sets receive-not-empty for it
// [RULE_09] mute writes only take effect while receive-not-empty is clear
// [RULE_10] with parity, address marker sits one below the parity bit
// [RULE_11] sync clock output runs only during data bits, never start or stop
// [RULE_12] last-bit pulse control gates the clock on the final data bit
// [RULE_13] polarity sets clock idle level, phase sets data-aligned edge
// [RULE_14] sync clock stays inactive while idle, preamble or break
// [RULE_15] sync reception uses one sample, never sets the noise flag
// [RULE_16] clock only while transmitter enabled and a written word shifts out
// [RULE_17] host changes clock settings only with transmitter and receiver off
// [RULE_18] host should enable transmitter and receiver in one write
// [RULE_19] clock pin is always an output, block is sync master only
// [RULE_20] idle frame is a full frame time with receive line held high
module umsc_top (
   input wire logic MCLK, // 40 MHz clock
   input wire logic RESET_N, // async reset
   input wire logic AWVALID, // write address valid
   output logic AWREADY, // write address ready
   input wire logic [7:0] AWADDR, // write address
   input wire logic WVALID, // write data valid
   output logic WREADY, // write data ready
   input wire logic [31:0] WDATA, // write data
   input wire logic [3:0] WSTRB, // byte strobes
   output logic BVALID, // write response valid
   input wire logic BREADY, // write response ready
   output logic [1:0] BRESP, // write response
   input wire logic ARVALID, // read address valid
   output logic ARREADY, // read address ready
   input wire logic [7:0] ARADDR, // read address
   output logic RVALID, // read data valid
   input wire logic RREADY, // read data ready
   output logic [31:0] RDATA, // read data
   output logic [1:0] RRESP, // read response
   input wire logic RXD, // serial receive pin
   output logic TXD, // serial transmit pin
   output logic SCLK // sync clock output
);

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic umsc_pkg::umsc_dec_t decode(input logic [7:0] a);
      umsc_pkg::umsc_dec_t d;
      d.hit = 1'b1;
      d.sel = umsc_pkg::DEC_DATA;
      case (a)
         umsc_pkg::ADDR_DATA: d.sel = umsc_pkg::DEC_DATA;
         umsc_pkg::ADDR_STATUS: d.sel = umsc_pkg::DEC_STATUS;
         umsc_pkg::ADDR_CTRL: d.sel = umsc_pkg::DEC_CTRL;
         umsc_pkg::ADDR_BAUD: d.sel = umsc_pkg::DEC_BAUD;
         default: d.hit = 1'b0;
      endcase
      return d;
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] st);
      return {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
   endfunction

   umsc_pkg::umsc_ctrl_t ctrl;
   logic [15:0] baud_div;
   logic mute, rx_not_empty_flag, idle_flag, noise_flag;
   logic [7:0] rx_data;
   logic aw_hold, w_hold;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   umsc_pkg::umsc_dec_t wdec, rdec;
   logic wr_fire, rd_fire, wr_data, wr_stat, wr_ctrl, rd_data;
   logic tx_busy;

   assign wdec = decode(aw_addr);
   assign rdec = decode(ARADDR);
   assign wr_fire = aw_hold && w_hold && !BVALID;
   assign rd_fire = ARVALID && ARREADY;
   assign wr_data = wr_fire && wdec.hit && wdec.sel == umsc_pkg::DEC_DATA;
   assign wr_stat = wr_fire && wdec.hit && wdec.sel == umsc_pkg::DEC_STATUS;
   assign wr_ctrl = wr_fire && wdec.hit && wdec.sel == umsc_pkg::DEC_CTRL;
   assign rd_data = rd_fire && rdec.hit && rdec.sel == umsc_pkg::DEC_DATA;

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         AWREADY <= 1'b0;
         WREADY <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         BVALID <= 1'b0;
         BRESP <= umsc_pkg::RESP_OKAY;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_hold <= 1'b1;
            aw_addr <= AWADDR;
            AWREADY <= 1'b0;
         end else if (wr_fire) begin
            aw_hold <= 1'b0;
         end else if (!aw_hold) begin
            AWREADY <= 1'b1;
         end
         if (WVALID && WREADY) begin
            w_hold <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
            WREADY <= 1'b0;
         end else if (wr_fire) begin
            w_hold <= 1'b0;
         end else if (!w_hold) begin
            WREADY <= 1'b1;
         end
         if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP <= wdec.hit ? umsc_pkg::RESP_OKAY : umsc_pkg::RESP_SLVERR;
         end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ARREADY <= 1'b0;
         RVALID <= 1'b0;
         RDATA <= 32'h0000_0000;
         RRESP <= umsc_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         ARREADY <= 1'b0;
         RVALID <= 1'b1;
         RRESP <= rdec.hit ? umsc_pkg::RESP_OKAY : umsc_pkg::RESP_SLVERR;
         RDATA <= 32'h0000_0000;
         if (rdec.hit) begin
            case (rdec.sel)
               umsc_pkg::DEC_DATA: RDATA <= {24'h000000, rx_data};
               umsc_pkg::DEC_STATUS: RDATA <= {27'h0000000, mute, tx_busy, noise_flag,
                                                idle_flag, rx_not_empty_flag};
               umsc_pkg::DEC_CTRL: begin
                  RDATA <= {16'h0000, ctrl};
                  RDATA[umsc_pkg::CTRL_MUTE] <= mute;
               end
               default: RDATA <= {16'h0000, baud_div};
            endcase
         end
      end else if (RVALID && RREADY) begin
         RVALID <= 1'b0;
      end else if (!RVALID) begin
         ARREADY <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ctrl <= umsc_pkg::CTRL_RST;
         baud_div <= umsc_pkg::BAUD_RST;
      end else if (wr_fire && wdec.hit) begin
         if (wdec.sel == umsc_pkg::DEC_CTRL)
            ctrl <= merge(ctrl, w_data, w_strb) & 16'hf0ff;
         if (wdec.sel == umsc_pkg::DEC_BAUD)
            baud_div <= merge(baud_div, w_data, w_strb);
      end
   end

   // ----------------------------------------------------------------
   // oversampling tick: sixteen per bit
   // ----------------------------------------------------------------
   logic [15:0] div_cnt;
   logic tick;
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         div_cnt <= 16'h0000;
         tick <= 1'b0;
      end else begin
         tick <= div_cnt <= 16'h0001;
         div_cnt <= (div_cnt <= 16'h0001) ? baud_div : div_cnt - 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // transmitter and sync clock
   // ----------------------------------------------------------------
   typedef enum {TX_IDLE, TX_START, TX_BITS, TX_STOP} umsc_tx_t;
   umsc_tx_t tx_state;
   logic [7:0] tx_shift;
   logic [3:0] tx_bit;
   logic [4:0] tx_tick;
   logic [7:0] tx_word;
   logic clk_act;

   assign tx_busy = tx_state != TX_IDLE;
   // parity replaces the top bit; even parity over the low seven
   assign tx_word = ctrl.parity_en ? {^w_data[6:0], w_data[6:0]} : w_data[7:0];

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         tx_state <= TX_IDLE;
         tx_shift <= 8'h00;
         tx_bit <= 4'h0;
         tx_tick <= 5'h00;
         TXD <= 1'b1;
      end else begin
         case (tx_state)
            TX_IDLE: begin
               TXD <= 1'b1;
               // [RULE_16] word written with transmitter on
               if (wr_data && ctrl.transmitter_enable && w_strb[0]) begin
                  tx_shift <= tx_word;
                  tx_state <= TX_START;
                  tx_tick <= 5'h00;
               end
            end
            TX_START: begin
               TXD <= 1'b0;
               if (tick) begin
                  tx_tick <= tx_tick + 5'h01;
                  if (tx_tick == umsc_pkg::OVS_TICKS - 5'h01) begin
                     tx_tick <= 5'h00;
                     tx_bit <= 4'h0;
                     tx_state <= TX_BITS;
                  end
               end
            end
            TX_BITS: begin
               TXD <= tx_shift[0];
               if (tick) begin
                  tx_tick <= tx_tick + 5'h01;
                  if (tx_tick == umsc_pkg::OVS_TICKS - 5'h01) begin
                     tx_tick <= 5'h00;
                     tx_shift <= {1'b0, tx_shift[7:1]};
                     tx_bit <= tx_bit + 4'h1;
                     if (tx_bit == umsc_pkg::DATA_BITS - 4'h1)
                        tx_state <= TX_STOP;
                  end
               end
            end
            TX_STOP: begin
               TXD <= 1'b1;
               if (tick) begin
                  tx_tick <= tx_tick + 5'h01;
                  if (tx_tick == umsc_pkg::OVS_TICKS - 5'h01)
                     tx_state <= TX_IDLE;
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // [RULE_11] pulses only inside data bits
   // [RULE_12] final bit gated by last-bit control
   // [RULE_13] phase picks first or second half
   always_comb begin
      clk_act = 1'b0;
      if (tx_state == TX_BITS && ctrl.sync_en && ctrl.transmitter_enable &&
          (tx_bit != umsc_pkg::DATA_BITS - 4'h1 || ctrl.last_bit_clock_pulse))
         clk_act = ctrl.clock_phase_select ? (tx_tick < umsc_pkg::MID_TICK) :
                                             (tx_tick >= umsc_pkg::MID_TICK);
   end

   // [RULE_14] otherwise resting at the polarity level
   // [RULE_19] pin is driven output only
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N)
         SCLK <= 1'b0;
      else
         SCLK <= ctrl.clock_polarity_select ^ clk_act;
   end

   // ----------------------------------------------------------------
   // receiver
   // ----------------------------------------------------------------
   logic rx_s1, rx_s2, rx_prev;
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
         rx_prev <= 1'b1;
      end else begin
         rx_s1 <= RXD;
         rx_s2 <= rx_s1;
         rx_prev <= rx_s2;
      end
   end

   typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP} umsc_rx_t;
   umsc_rx_t rx_state;
   logic [7:0] rx_shift;
   logic [3:0] rx_bit;
   logic [4:0] rx_tick;
   logic [2:0] smp;
   logic bit_val, bit_noisy, char_done, noise_seen;
   logic [7:0] idle_cnt;
   logic idle_ev, idle_armed;

   // [RULE_15] single sample in sync mode, majority of three otherwise
   assign bit_val = ctrl.sync_en ? smp[1] :
                    (smp[0] & smp[1]) | (smp[1] & smp[2]) | (smp[0] & smp[2]);
   assign bit_noisy = !ctrl.sync_en && !(&smp || ~|smp);

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rx_state <= RX_IDLE;
         rx_shift <= 8'h00;
         rx_bit <= 4'h0;
         rx_tick <= 5'h00;
         smp <= 3'h7;
         char_done <= 1'b0;
         noise_seen <= 1'b0;
      end else begin
         char_done <= 1'b0;
         if (tick && rx_state != RX_IDLE) begin
            rx_tick <= rx_tick + 5'h01;
            if (rx_tick >= umsc_pkg::MID_TICK - 5'h01 && rx_tick <= umsc_pkg::MID_TICK + 5'h01)
               smp <= {smp[1:0], rx_s2};
         end
         case (rx_state)
            RX_IDLE: begin
               if (ctrl.receiver_enable && rx_prev && !rx_s2) begin
                  rx_state <= RX_START;
                  rx_tick <= 5'h00;
                  noise_seen <= 1'b0;
               end
            end
            RX_START: begin
               if (tick && rx_tick == umsc_pkg::OVS_TICKS - 5'h01) begin
                  rx_tick <= 5'h00;
                  rx_bit <= 4'h0;
                  rx_state <= bit_val ? RX_IDLE : RX_BITS;
               end
            end
            RX_BITS: begin
               if (tick && rx_tick == umsc_pkg::OVS_TICKS - 5'h01) begin
                  rx_tick <= 5'h00;
                  rx_shift <= {bit_val, rx_shift[7:1]};
                  noise_seen <= noise_seen | bit_noisy;
                  rx_bit <= rx_bit + 4'h1;
                  if (rx_bit == umsc_pkg::DATA_BITS - 4'h1)
                     rx_state <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (tick && rx_tick == umsc_pkg::MID_TICK) begin
                  char_done <= 1'b1;
                  rx_state <= RX_IDLE;
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // [RULE_20] a whole frame time of high line, once per idle stretch
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         idle_cnt <= 8'h00;
         idle_ev <= 1'b0;
         idle_armed <= 1'b0;
      end else begin
         idle_ev <= 1'b0;
         if (!ctrl.receiver_enable || !rx_s2 || rx_state != RX_IDLE) begin
            idle_cnt <= 8'h00;
            idle_armed <= ctrl.receiver_enable;
         end else if (tick && idle_armed) begin
            idle_cnt <= idle_cnt + 8'h01;
            if (idle_cnt == umsc_pkg::IDLE_TICKS - 8'h01) begin
               idle_ev <= 1'b1;
               idle_armed <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // mute and receive flags
   // ----------------------------------------------------------------
   logic is_addr, addr_match, accept;
   // [RULE_10] marker one below parity
   // [RULE_06] marker set means address
   assign is_addr = ctrl.parity_en ? rx_shift[6] : rx_shift[7];
   assign addr_match = rx_shift[3:0] == ctrl.node_addr;
   // [RULE_01] muted characters raise nothing
   // [RULE_08] matching address itself is delivered
   assign accept = char_done && (ctrl.wake && is_addr ? addr_match : !mute);

   // [RULE_02] wake bit picks method
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         mute <= 1'b0;
      end else if (ctrl.wake && char_done && is_addr) begin
         // [RULE_07] foreign address mutes
         mute <= !addr_match;
      end else if (!ctrl.wake && idle_ev && mute) begin
         // [RULE_04] idle frame wakes
         mute <= 1'b0;
      end else if (wr_ctrl && w_strb[1] && !rx_not_empty_flag) begin
         // [RULE_09] write honoured only with receive buffer empty
         // [RULE_03] [RULE_05] software enters or leaves mute
         mute <= w_data[umsc_pkg::CTRL_MUTE];
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rx_not_empty_flag <= 1'b0;
         rx_data <= 8'h00;
         idle_flag <= 1'b0;
         noise_flag <= 1'b0;
      end else begin
         if (accept) begin
            rx_not_empty_flag <= 1'b1;
            rx_data <= rx_shift;
         end else if (rd_data) begin
            rx_not_empty_flag <= 1'b0;
         end
         // [RULE_04] no idle flag while muted
         if (idle_ev && !mute)
            idle_flag <= 1'b1;
         else if (wr_stat && w_strb[0] && w_data[umsc_pkg::ST_IDLE])
            idle_flag <= 1'b0;
         // [RULE_15] noise only from async majority
         if (accept && noise_seen)
            noise_flag <= 1'b1;
         else if (wr_stat && w_strb[0] && w_data[umsc_pkg::ST_NOISE])
            noise_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);

   sequence s_foreign_addr;
      ctrl.wake && char_done && is_addr && !addr_match;
   endsequence
   sequence s_own_addr;
      ctrl.wake && char_done && is_addr && addr_match;
   endsequence

   a_mute_no_rx_not_empty_flag: assert property ( // [RULE_01]
      char_done && mute && !(ctrl.wake && is_addr) && !rd_data |=> $stable(rx_not_empty_flag))
      else $error("muted character changed rx_not_empty_flag");
   a_foreign_mutes: assert property ( // [RULE_07]
      s_foreign_addr ##0 !rd_data |=> mute && $stable(rx_not_empty_flag))
      else $error("foreign address did not mute");
   a_own_wakes: assert property ( // [RULE_08]
      s_own_addr |=> !mute && rx_not_empty_flag && rx_data[3:0] == ctrl.node_addr)
      else $error("own address not delivered");
   a_idle_wakes: assert property ( // [RULE_04]
      !ctrl.wake && idle_ev && mute |=> !mute && !$rose(idle_flag))
      else $error("idle frame wake wrong");
   a_mute_write_gate: assert property ( // [RULE_09]
      wr_ctrl && w_strb[1] && rx_not_empty_flag && !char_done && !idle_ev |=> $stable(mute))
      else $error("mute write taken with rx_not_empty_flag set");
   // sclk is registered, so compare against the polarity it was built from
   a_sync_clk_rest: assert property ( // [RULE_11]
      tx_state != TX_BITS |=> SCLK == $past(ctrl.clock_polarity_select))
      else $error("sync clock pulsed outside data bits");
   a_last_bit_gate: assert property ( // [RULE_12]
      tx_state == TX_BITS && tx_bit == umsc_pkg::DATA_BITS - 4'h1 &&
      !ctrl.last_bit_clock_pulse |=> SCLK == $past(ctrl.clock_polarity_select))
      else $error("last bit pulse not suppressed");
   a_sync_no_noise: assert property ( // [RULE_15]
      ctrl.sync_en && accept && !noise_flag && !(wr_stat && w_strb[0]) |=> !noise_flag)
      else $error("noise in sync mode");
   a_tx_needs_en: assert property ( // [RULE_16]
      $rose(tx_busy) |-> $past(ctrl.transmitter_enable))
      else $error("transmit started while disabled");

endmodule

// File: verilog/umsc_pkg.sv
package umsc_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_BAUD = 8'h0c;

   // status bit positions
   localparam int ST_RX_NOT_EMPTY_FLAG = 0;
   localparam int ST_IDLE = 1;
   localparam int ST_NOISE = 2;
   localparam int ST_TXBUSY = 3;
   localparam int ST_MUTE = 4;
   // position of the mute bit inside the control word
   localparam int CTRL_MUTE = 8;

   // ----------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] BAUD_RST = 16'h0010;
   localparam logic [4:0] OVS_TICKS = 5'h10;
   localparam logic [4:0] MID_TICK = 5'h08;
   localparam logic [3:0] DATA_BITS = 4'h8;
   localparam logic [7:0] IDLE_TICKS = 8'ha0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [3:0] node_addr;
      logic [3:0] rsvd;
      logic last_bit_clock_pulse;
      logic clock_phase_select;
      logic clock_polarity_select;
      logic sync_en;
      logic parity_en;
      logic wake;
      logic receiver_enable;
      logic transmitter_enable;
   } umsc_ctrl_t;

   typedef enum logic [1:0] {DEC_DATA, DEC_STATUS, DEC_CTRL, DEC_BAUD} umsc_reg_t;

   typedef struct packed {
      logic hit;
      umsc_reg_t sel;
   } umsc_dec_t;

endpackage

// File: test/umsc_node.sv
`timescale 1ns/1ps
module umsc_node #(
   parameter int BIT_CYC = 32
) (
   input wire logic clk, // bench clock
   input wire logic go, // send one frame
   input wire logic [7:0] byte_in, // frame payload
   output logic line, // serial line into the block
   output logic busy // frame under way
);
   initial begin
      line = 1'b1;
      busy = 1'b0;
   end
   always @(posedge clk) begin
      if (go && !busy) begin
         busy <= 1'b1;
         for (int i = 0; i < 10; i++) begin
            line <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : byte_in[i - 1];
            repeat (BIT_CYC) @(posedge clk);
         end
         busy <= 1'b0;
      end
   end
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
   logic mclk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, go = 0;
   logic [7:0] awa = 0, ara = 0, nb = 0, sh = 0;
   logic [31:0] wd = 0, rdata, rd;
   logic [1:0] bresp, rresp, rr, br;
   logic awr, wr_r, bv, arr, rv, txd, sclk, rxd, nbusy, sq = 0, pol = 0;
   int mismatches = 0, num_checks = 0, pulses = 0, seed = 32'ha092;
   always #12.5 mclk = ~mclk;
   umsc_top umsc_top_inst (.MCLK(mclk), .RESET_N(rst_n), .AWVALID(awv), .AWREADY(awr),
      .AWADDR(awa), .WVALID(wv), .WREADY(wr_r), .WDATA(wd), .WSTRB(4'hf), .BVALID(bv),
      .BREADY(bry), .BRESP(bresp), .ARVALID(arv), .ARREADY(arr), .ARADDR(ara),
      .RVALID(rv), .RREADY(rry), .RDATA(rdata), .RRESP(rresp), .RXD(rxd), .TXD(txd),
      .SCLK(sclk));
   umsc_node #(.BIT_CYC(32)) umsc_node_inst (.clk(mclk), .go(go), .byte_in(nb),
      .line(rxd), .busy(nbusy));
   // active clock edges leave the idle level; tx bit captured at each
   always @(posedge mclk) begin
      sq <= sclk;
      if (sq === pol && sclk === !pol) begin
         pulses <= pulses + 1;
         sh <= {txd, sh[7:1]};
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wrt(input logic [7:0] a, input logic [31:0] d);
      logic ad = 1'b0;
      logic dd = 1'b0;
      @(posedge mclk);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= d;
      bry <= 1'b1;
      do begin
         @(posedge mclk);
         if (!ad && awr === 1'b1) begin
            ad = 1'b1;
            awv <= 1'b0;
         end
         if (!dd && wr_r === 1'b1) begin
            dd = 1'b1;
            wv <= 1'b0;
         end
      end while (!(ad && dd));
      do @(posedge mclk); while (bv !== 1'b1);
      br = bresp;
      bry <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge mclk);
      arv <= 1'b1;
      ara <= a;
      rry <= 1'b1;
      do @(posedge mclk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge mclk); while (rv !== 1'b1);
      rd = rdata;
      rr = rresp;
      rry <= 1'b0;
   endtask
   task automatic send(input logic [7:0] v);
      @(posedge mclk);
      nb <= v;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      do @(posedge mclk); while (nbusy === 1'b1);
      repeat (8) @(posedge mclk);
   endtask
   task automatic stat(input logic m, input logic r);
      rdr(umsc_pkg::ADDR_STATUS);
      check({rd[umsc_pkg::ST_MUTE], rd[umsc_pkg::ST_RX_NOT_EMPTY_FLAG]}, {m, r});
   endtask
   initial begin
      logic [7:0] t [6];
      logic [7:0] b;
      int p0;
      int cfg;
      t = '{8'h83, 8'h15, 8'h85, 8'hc3, 8'h85, 8'hc5};
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      rdr(umsc_pkg::ADDR_CTRL);
      check(rd, {16'h0, umsc_pkg::CTRL_RST});
      rdr(umsc_pkg::ADDR_BAUD);
      check(rd, {16'h0, umsc_pkg::BAUD_RST});
      rdr(8'h10);
      check({rr, rd[7:0]}, {umsc_pkg::RESP_SLVERR, 8'h0});
      wrt(umsc_pkg::ADDR_BAUD, 32'h2);
      check(br, umsc_pkg::RESP_OKAY);
      wrt(8'h10, 32'h0);
      check(br, umsc_pkg::RESP_SLVERR);
      $display("test registers done");
      for (int p = 0; p < 2; p++) begin
         wrt(umsc_pkg::ADDR_CTRL, 32'h5007 | (p << 3));
         send(t[3 * p]);
         stat(1'b1, 1'b0);
         send(t[3 * p + 1]);
         stat(1'b1, 1'b0);
         send(t[3 * p + 2]);
         stat(1'b0, 1'b1);
         wrt(umsc_pkg::ADDR_CTRL, 32'h5107 | (p << 3));
         stat(1'b0, 1'b1);
         rdr(umsc_pkg::ADDR_DATA);
         check(rd[7:0], t[3 * p + 2]);
      end
      $display("test address wake done");
      wrt(umsc_pkg::ADDR_CTRL, 32'h3);
      repeat (400) @(posedge mclk);
      wrt(umsc_pkg::ADDR_STATUS, 32'h6);
      wrt(umsc_pkg::ADDR_CTRL, 32'h103);
      stat(1'b1, 1'b0);
      b = $random(seed);
      send(b);
      stat(1'b1, 1'b0);
      repeat (400) @(posedge mclk);
      stat(1'b0, 1'b0);
      check(rd[umsc_pkg::ST_IDLE], 1'b0);
      send(b);
      rdr(umsc_pkg::ADDR_DATA);
      check(rd[7:0], b);
      wrt(umsc_pkg::ADDR_CTRL, 32'h103);
      wrt(umsc_pkg::ADDR_CTRL, 32'h3);
      stat(1'b0, 1'b0);
      $display("test idle wake done");
      for (int k = 0; k < 3; k++) begin
         pol = k[0];
         cfg = 32'h10 | (k[0] << 5) | (k[0] << 6) | (k[0] << 7);
         wrt(umsc_pkg::ADDR_CTRL, 32'h0);
         wrt(umsc_pkg::ADDR_CTRL, cfg);
         wrt(umsc_pkg::ADDR_CTRL, cfg | ((k < 2) ? 3 : 2));
         check(sclk, pol);
         p0 = pulses;
         b = $random(seed);
         wrt(umsc_pkg::ADDR_DATA, {24'h0, b});
         rdr(umsc_pkg::ADDR_STATUS);
         check(rd[umsc_pkg::ST_TXBUSY], k < 2);
         send(b ^ 8'h5a);
         repeat (400) @(posedge mclk);
         check(pulses - p0, (k == 2) ? 0 : 7 + k);
         if (k == 1) check(sh, b);
         check(sclk, pol);
         rdr(umsc_pkg::ADDR_STATUS);
         check(rd[umsc_pkg::ST_NOISE], 1'b0);
         rdr(umsc_pkg::ADDR_DATA);
         check(rd[7:0], b ^ 8'h5a);
      end
      $display("test sync clock done");
      complete_run;
   end
   initial begin
      #1000000;
      mismatches++;
      complete_run;
   end
endmodule
